// File: rtl/trb_bank.sv
/*
  Terminal register bank: one 64-word register set per logical channel,
  reached over AHB-Lite. Unlocked parameter writes are mirrored on a write port
  toward an external serial EEPROM engine; command writes are strobed out.
  Assumes a single AHB-Lite master doing single word transfers, and that
  the EEPROM engine restores parameters through the load port.
*/
`timescale 1ns/100ps

module trb_bank (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [trb_pkg::NUM_CHAN-1:0][15:0] diag_in,
  input wire logic [trb_pkg::NUM_CHAN-1:0][7:0] cmd_result,
  input wire logic [trb_pkg::NUM_CHAN-1:0][15:0] pv_in,
  input wire logic nv_load,
  input wire trb_pkg::trb_nv_wr_t nv_load_word,
  output logic nv_wr_valid,
  output trb_pkg::trb_nv_wr_t nv_wr,
  output logic [trb_pkg::NUM_CHAN-1:0] cmd_strobe,
  output logic [trb_pkg::NUM_CHAN-1:0][15:0] cmd_word,
  output logic [trb_pkg::NUM_CHAN-1:0][15:0] features
);

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // A parameter index lies in the EEPROM-backed areas, key excluded.
  function automatic logic is_param(input logic [5:0] idx);
    is_param = (idx >= trb_pkg::IDX_MFR_FIRST) &&
      (idx <= trb_pkg::IDX_USER_LAST) &&
      (idx != trb_pkg::IDX_WRITE_UNLOCK_KEY);
  endfunction

  function automatic logic [15:0] type_word(input logic [5:0] idx);
    case (idx)
      trb_pkg::IDX_TERMINAL_TYPE_ID: type_word = trb_pkg::TYPE_ID_VAL;
      trb_pkg::IDX_SOFTWARE_VERSION:
        type_word = trb_pkg::SW_VERSION_VAL;
      trb_pkg::IDX_SHIFT_DATA_LENGTH:
        type_word = trb_pkg::SHIFT_LEN_VAL;
      trb_pkg::IDX_LOGICAL_CHANNEL_COUNT:
        type_word = trb_pkg::CHAN_COUNT_VAL;
      trb_pkg::IDX_MIN_TRANSFER_LENGTH:
        type_word = trb_pkg::MIN_LEN_VAL;
      trb_pkg::IDX_DATA_TYPE_CODE:
        type_word = {8'h00, trb_pkg::DTYPE_WORD_ARRAY};
      default: type_word = trb_pkg::ZERO_WORD;
    endcase
  endfunction

  trb_pkg::trb_state_t s_q;
  trb_pkg::trb_state_t s_d;

  logic addr_ok;
  logic [trb_pkg::CHAN_BITS-1:0] a_chan;
  logic [5:0] a_idx;
  logic [15:0] wr16;

  assign a_idx = haddr[7:2];
  assign a_chan = haddr[8 +: trb_pkg::CHAN_BITS];
  // Only whole-word transfers are taken; narrower ones are ignored.
  assign addr_ok = hsel && hready && (htrans == trb_pkg::HTRANS_NONSEQ) &&
    (hsize == trb_pkg::HSIZE_WORD);
  assign wr16 = hwdata[15:0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [15:0] rv;
    logic [5:0] ix;
    logic [trb_pkg::CHAN_BITS-1:0] ch;
    rv = trb_pkg::ZERO_WORD;
    ix = s_q.ph_idx;
    ch = s_q.ph_chan;
    s_d = s_q;
    s_d.nv_valid = 1'b0;
    s_d.cmd_strobe = '0;
    // Live process inputs land in the volatile area every cycle.
    for (int c = 0; c < trb_pkg::NUM_CHAN; c++)
    begin
      s_d.regs[c][5] = pv_in[c];
      s_d.regs[c][trb_pkg::IDX_DIAGNOSTIC_INFO] = diag_in[c];
      s_d.regs[c][trb_pkg::IDX_FUNCTION_COMMAND][15:8] =
        cmd_result[c];
    end
    // EEPROM restore comes first so a bus write in the same cycle wins.
    if (nv_load && is_param(nv_load_word.addr[5:0]))
    begin
      s_d.regs[nv_load_word.addr[6 +: trb_pkg::CHAN_BITS]]
        [nv_load_word.addr[5:0]] = nv_load_word.data;
    end
    if (s_q.ph_wr)
    begin
      if (ix <= trb_pkg::IDX_PV_LAST)
      begin
        if (ix == trb_pkg::IDX_FUNCTION_COMMAND)
        begin
          s_d.regs[ch][ix][7:0] = wr16[7:0];
          s_d.cmd_strobe[ch] = 1'b1;
          s_d.cmd_word[ch] = wr16;
        end
        else if (ix != trb_pkg::IDX_DIAGNOSTIC_INFO && ix != 6'h05)
        begin
          s_d.regs[ch][ix] = wr16;
        end
      end
      else if (ix == trb_pkg::IDX_WRITE_UNLOCK_KEY)
      begin
        s_d.unlocked[ch] = (wr16 == trb_pkg::UNLOCK_CODE);
        s_d.regs[ch][ix] = wr16;
      end
      else if (is_param(ix))
      begin
        if (s_q.unlocked[ch])
        begin
          s_d.regs[ch][ix] = wr16;
          s_d.nv_valid = 1'b1;
          s_d.nv.addr = {9'h000, ch, ix};
          s_d.nv.data = wr16;
        end
      end
      else if (ix > trb_pkg::IDX_USER_LAST)
      begin
        s_d.regs[ch][ix] = wr16;
      end
    end
    s_d.ph_wr = addr_ok && hwrite;
    s_d.ph_chan = a_chan;
    s_d.ph_idx = a_idx;
    // Reads look at the next state, so a write in its data phase is seen
    // by a read whose address phase shares that cycle.
    if (addr_ok && !hwrite)
    begin
      if (a_idx >= trb_pkg::IDX_TYPE_FIRST && a_idx <= trb_pkg::IDX_TYPE_LAST)
      begin
        rv = type_word(a_idx);
        if (a_idx == trb_pkg::IDX_BYTE_ALIGNMENT_BITS)
        begin
          rv = s_d.regs[a_chan][a_idx];
        end
      end
      else if (a_idx == trb_pkg::IDX_WRITE_UNLOCK_KEY)
      begin
        rv = s_d.unlocked[a_chan] ? s_d.regs[a_chan][a_idx] :
          trb_pkg::ZERO_WORD;
      end
      else
      begin
        rv = s_d.regs[a_chan][a_idx];
      end
      s_d.rdata = {16'h0000, rv};
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      for (int c = 0; c < trb_pkg::NUM_CHAN; c++)
      begin
        s_q.regs[c][trb_pkg::IDX_OPERATING_FEATURES] <=
          trb_pkg::FEATURE_RESET;
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Zero wait states keep the slave simple; the read word is fetched in
  // the address phase so it stands in the data phase.
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign nv_wr_valid = s_q.nv_valid;
  assign nv_wr = s_q.nv;
  assign cmd_strobe = s_q.cmd_strobe;
  assign cmd_word = s_q.cmd_word;
  always_comb
  begin
    for (int c = 0; c < trb_pkg::NUM_CHAN; c++)
    begin
      features[c] = s_q.regs[c][trb_pkg::IDX_OPERATING_FEATURES];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_lock_key;
    @(posedge sys_clk) disable iff (!rstn)
    s_q.ph_wr && s_q.ph_idx == trb_pkg::IDX_WRITE_UNLOCK_KEY
    |=> s_q.unlocked[$past(s_q.ph_chan)] ==
      ($past(wr16) == trb_pkg::UNLOCK_CODE);
  endproperty
  a_lock_key: assert property (p_lock_key)
    else $error("unlock state does not follow key write");

  property p_locked_no_nv;
    @(posedge sys_clk) disable iff (!rstn)
    s_q.ph_wr && is_param(s_q.ph_idx) && !s_q.unlocked[s_q.ph_chan]
    |=> !nv_wr_valid;
  endproperty
  a_locked_no_nv: assert property (p_locked_no_nv)
    else $error("locked parameter write reached EEPROM");

  property p_unlocked_nv;
    @(posedge sys_clk) disable iff (!rstn)
    s_q.ph_wr && is_param(s_q.ph_idx) && s_q.unlocked[s_q.ph_chan]
    |=> nv_wr_valid && nv_wr.data == $past(wr16);
  endproperty
  a_unlocked_nv: assert property (p_unlocked_nv)
    else $error("unlocked parameter write not mirrored");

  property p_key_read;
    @(posedge sys_clk) disable iff (!rstn)
    addr_ok && !hwrite && a_idx == trb_pkg::IDX_WRITE_UNLOCK_KEY &&
      !s_d.unlocked[a_chan] |=> hrdata == 32'h00000000;
  endproperty
  a_key_read: assert property (p_key_read)
    else $error("locked key read not zero");

  property p_type_read;
    @(posedge sys_clk) disable iff (!rstn)
    addr_ok && !hwrite && a_idx == trb_pkg::IDX_DATA_TYPE_CODE
    |=> hrdata == 32'h00000003;
  endproperty
  a_type_read: assert property (p_type_read)
    else $error("data type code wrong");

  property p_type_ro;
    @(posedge sys_clk) disable iff (!rstn)
    addr_ok && !hwrite && a_idx == trb_pkg::IDX_TERMINAL_TYPE_ID
    |=> hrdata[15:0] == trb_pkg::TYPE_ID_VAL;
  endproperty
  a_type_ro: assert property (p_type_ro)
    else $error("type id changed");

  sequence s_cmd_taken;
    s_q.ph_wr && s_q.ph_idx == trb_pkg::IDX_FUNCTION_COMMAND;
  endsequence

  sequence s_cmd_pulse;
    cmd_strobe[$past(s_q.ph_chan)] &&
      cmd_word[$past(s_q.ph_chan)] == $past(wr16);
  endsequence

  property p_cmd_strobe;
    @(posedge sys_clk) disable iff (!rstn)
    s_cmd_taken |=> s_cmd_pulse;
  endproperty
  a_cmd_strobe: assert property (p_cmd_strobe)
    else $error("command strobe missing or word wrong");

  // Back-to-back command writes are legal, so a stuck strobe is caught
  // by demanding a command write behind every strobe cycle instead.
  property p_cmd_only;
    @(posedge sys_clk) disable iff (!rstn)
    cmd_strobe != 2'h0 |-> $past(s_q.ph_wr) &&
      $past(s_q.ph_idx) == trb_pkg::IDX_FUNCTION_COMMAND;
  endproperty
  a_cmd_only: assert property (p_cmd_only)
    else $error("command strobe without command write");

  property p_key_not_nv;
    @(posedge sys_clk) disable iff (!rstn)
    nv_wr_valid |-> nv_wr.addr[5:0] != trb_pkg::IDX_WRITE_UNLOCK_KEY;
  endproperty
  a_key_not_nv: assert property (p_key_not_nv)
    else $error("key sent to EEPROM");

  property p_mfr_locked_hold;
    @(posedge sys_clk) disable iff (!rstn)
    s_q.ph_wr && s_q.ph_idx == trb_pkg::IDX_MFR_FIRST &&
      !s_q.unlocked[s_q.ph_chan] && !nv_load
    |=> $stable(s_q.regs[$past(s_q.ph_chan)][trb_pkg::IDX_MFR_FIRST]);
  endproperty
  a_mfr_locked_hold: assert property (p_mfr_locked_hold)
    else $error("locked manufacturer write stored");

  property p_pv_read;
    @(posedge sys_clk) disable iff (!rstn)
    addr_ok && !hwrite && a_idx == 6'h05 && a_chan == 1'b0
    |=> hrdata[15:0] == $past(pv_in[0]);
  endproperty
  a_pv_read: assert property (p_pv_read)
    else $error("live process value not read back");

  property p_diag_read;
    @(posedge sys_clk) disable iff (!rstn)
    addr_ok && !hwrite && a_idx == trb_pkg::IDX_DIAGNOSTIC_INFO &&
      a_chan == 1'b1 |=> hrdata[15:0] == $past(diag_in[1]);
  endproperty
  a_diag_read: assert property (p_diag_read)
    else $error("diagnostic value not read back");

  property p_cmd_read;
    @(posedge sys_clk) disable iff (!rstn)
    addr_ok && !hwrite && a_idx == trb_pkg::IDX_FUNCTION_COMMAND
    |=> hrdata[15:8] == $past(cmd_result[a_chan]);
  endproperty
  a_cmd_read: assert property (p_cmd_read)
    else $error("command result not in high byte");

  property p_type_wr_ignored;
    @(posedge sys_clk) disable iff (!rstn)
    s_q.ph_wr && s_q.ph_idx >= trb_pkg::IDX_TYPE_FIRST &&
      s_q.ph_idx <= trb_pkg::IDX_TYPE_LAST
    |=> $stable(s_q.regs[$past(s_q.ph_chan)][$past(s_q.ph_idx)]);
  endproperty
  a_type_wr_ignored: assert property (p_type_wr_ignored)
    else $error("type register changed by a write");

  property p_feat_locked;
    @(posedge sys_clk) disable iff (!rstn)
    s_q.ph_wr && s_q.ph_idx == trb_pkg::IDX_OPERATING_FEATURES &&
      !s_q.unlocked[s_q.ph_chan] && !nv_load
    |=> $stable(features[$past(s_q.ph_chan)]);
  endproperty
  a_feat_locked: assert property (p_feat_locked)
    else $error("locked feature write stored");

  property p_ext_write;
    @(posedge sys_clk) disable iff (!rstn)
    s_q.ph_wr && s_q.ph_idx > trb_pkg::IDX_USER_LAST
    |=> s_q.regs[$past(s_q.ph_chan)][$past(s_q.ph_idx)] == $past(wr16);
  endproperty
  a_ext_write: assert property (p_ext_write)
    else $error("extended area write lost");

  property p_nv_param;
    @(posedge sys_clk) disable iff (!rstn)
    nv_wr_valid |-> is_param(nv_wr.addr[5:0]) &&
      s_q.regs[nv_wr.addr[6 +: trb_pkg::CHAN_BITS]][nv_wr.addr[5:0]] ==
      nv_wr.data;
  endproperty
  a_nv_param: assert property (p_nv_param)
    else $error("EEPROM word differs from stored parameter");

endmodule

// File: rtl/trb_pkg.sv
/*
  Package for the terminal register bank: register indices, area bounds,
  reset values, code word, data type codes and the state carrier struct.
  Assumes an AHB-Lite slave with 32-bit data and one word per register.
*/
package trb_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CHAN = 2;
  localparam int unsigned NUM_REGS = 64;
  localparam int unsigned CHAN_BITS = 1;
  localparam logic [5:0] IDX_PV_LAST = 6'h07;
  localparam logic [5:0] IDX_TYPE_FIRST = 6'h08;
  localparam logic [5:0] IDX_TYPE_LAST = 6'h0F;
  localparam logic [5:0] IDX_MFR_FIRST = 6'h10;
  localparam logic [5:0] IDX_MFR_LAST = 6'h1E;
  localparam logic [5:0] IDX_USER_LAST = 6'h2F;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_DIAGNOSTIC_INFO = 6'h06;
  localparam logic [5:0] IDX_FUNCTION_COMMAND = 6'h07;
  localparam logic [5:0] IDX_TERMINAL_TYPE_ID = 6'h08;
  localparam logic [5:0] IDX_SOFTWARE_VERSION = 6'h09;
  localparam logic [5:0] IDX_SHIFT_DATA_LENGTH = 6'h0A;
  localparam logic [5:0] IDX_LOGICAL_CHANNEL_COUNT = 6'h0B;
  localparam logic [5:0] IDX_MIN_TRANSFER_LENGTH = 6'h0C;
  localparam logic [5:0] IDX_DATA_TYPE_CODE = 6'h0D;
  localparam logic [5:0] IDX_RESERVED_TYPE_SLOT = 6'h0E;
  localparam logic [5:0] IDX_BYTE_ALIGNMENT_BITS = 6'h0F;
  localparam logic [5:0] IDX_WRITE_UNLOCK_KEY = 6'h1F;
  localparam logic [5:0] IDX_OPERATING_FEATURES = 6'h20;

  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  localparam logic [15:0] UNLOCK_CODE = 16'h1235;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  // Identity value is arbitrary.
  localparam logic [15:0] TYPE_ID_VAL = 16'h0A5C;
  // Two ASCII characters "1" and "0".
  localparam logic [15:0] SW_VERSION_VAL = 16'h3130;
  localparam logic [15:0] SHIFT_LEN_VAL = 16'h0110;
  localparam logic [15:0] CHAN_COUNT_VAL = 16'h0001;
  localparam logic [15:0] MIN_LEN_VAL = 16'h0002;
  localparam logic [7:0] DTYPE_NONE = 8'h00;
  localparam logic [7:0] DTYPE_BYTE_ARRAY = 8'h01;
  localparam logic [7:0] DTYPE_WORD_ARRAY = 8'h03;
  localparam logic [7:0] DTYPE_DWORD_ARRAY = 8'h05;
  localparam logic [7:0] DTYPE_VAR_WORD_ARRAY = 8'h13;
  localparam logic [15:0] ALIGN_RESET = 16'h0000;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [15:0] FEATURE_RESET = 16'h0006;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } trb_nv_wr_t;

  typedef struct packed {
    logic [NUM_CHAN-1:0][NUM_REGS-1:0][15:0] regs;
    logic [NUM_CHAN-1:0] unlocked;
    logic ph_wr;
    logic [CHAN_BITS-1:0] ph_chan;
    logic [5:0] ph_idx;
    logic [31:0] rdata;
    logic nv_valid;
    trb_nv_wr_t nv;
    logic [NUM_CHAN-1:0] cmd_strobe;
    logic [NUM_CHAN-1:0][15:0] cmd_word;
  } trb_state_t;

endpackage

// File: test/terminal_register_bank_bench.sv
/*
  Self-checking bench for the terminal register bank.
  Assumes a zero-wait AHB-Lite slave and the EEPROM engine model.
*/
`timescale 1ns/100ps
module terminal_register_bank_bench;
  typedef struct packed {
    logic wr;
    logic [5:0] idx;
    logic [15:0] wd;
    logic [15:0] ex;
  } trb_row_t;

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = trb_pkg::HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [1:0][15:0] diag_in = '0;
  logic [1:0][7:0] cmd_result = '0;
  logic [1:0][15:0] pv_in = '0;
  logic nv_load;
  trb_pkg::trb_nv_wr_t nv_load_word;
  logic nv_wr_valid;
  trb_pkg::trb_nv_wr_t nv_wr;
  logic [1:0] cmd_strobe;
  logic [1:0][15:0] cmd_word;
  logic [1:0][15:0] features;
  logic [15:0] rd;
  int failures = 0;
  int num_checks = 0;
  trb_row_t rows [18] = '{
    '{1'b0, 6'h08, 16'h0000, 16'h0A5C},
    '{1'b0, 6'h09, 16'h0000, 16'h3130},
    '{1'b0, 6'h0A, 16'h0000, 16'h0110},
    '{1'b0, 6'h0B, 16'h0000, 16'h0001},
    '{1'b0, 6'h0C, 16'h0000, 16'h0002},
    '{1'b0, 6'h0D, 16'h0000, 16'h0003},
    '{1'b0, 6'h0E, 16'h0000, 16'h0000},
    '{1'b1, 6'h0F, 16'h00FF, 16'h0000},
    '{1'b1, 6'h08, 16'hFFFF, 16'h0A5C},
    '{1'b1, 6'h00, 16'h00FF, 16'h00FF},
    '{1'b1, 6'h10, 16'hABCD, 16'h0000},
    '{1'b1, 6'h20, 16'h0000, 16'h0006},
    '{1'b1, 6'h1F, 16'h1235, 16'h1235},
    '{1'b1, 6'h10, 16'hABCD, 16'hABCD},
    '{1'b1, 6'h2F, 16'h5A5A, 16'h5A5A},
    '{1'b1, 6'h1F, 16'h1234, 16'h0000},
    '{1'b1, 6'h10, 16'h1111, 16'hABCD},
    '{1'b1, 6'h3F, 16'hC3C3, 16'hC3C3}
  };

  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;

  trb_bank dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .diag_in(diag_in), .cmd_result(cmd_result),
    .pv_in(pv_in), .nv_load(nv_load), .nv_load_word(nv_load_word),
    .nv_wr_valid(nv_wr_valid), .nv_wr(nv_wr), .cmd_strobe(cmd_strobe),
    .cmd_word(cmd_word), .features(features)
  );

  trb_eeprom_model eep_u (
    .sys_clk(sys_clk), .nv_wr_valid(nv_wr_valid), .nv_wr(nv_wr),
    .nv_load(nv_load), .nv_load_word(nv_load_word)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] ex,
                     input logic [15:0] got);
    num_checks++;
    if (got !== ex)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      failures++;
      test_done();
    end
  endtask

  task automatic bus(input logic w, input logic ch, input logic [5:0] idx,
                     input logic [15:0] wd, output logic [15:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {23'h000000, ch, idx, 2'h0};
    htrans <= trb_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    wait_rdy();
    q = hrdata[15:0];
  endtask

  // Write on channel 0 whose data phase carries the read address phase.
  task automatic wr_rd(input logic [5:0] idx, input logic [15:0] wd,
                       output logic [15:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, idx, 2'h0};
    htrans <= trb_pkg::HTRANS_NONSEQ;
    hwrite <= 1'b1;
    wait_rdy();
    hwrite <= 1'b0;
    hwdata <= {16'h0000, wd};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    q = hrdata[15:0];
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        bus(1'b1, 1'b0, rows[i].idx, rows[i].wd, rd);
      bus(1'b0, 1'b0, rows[i].idx, 16'h0000, rd);
      chk("row read", rows[i].ex, rd);
    end
    chk("nv writes", 16'h0002, 16'(eep_u.num_wr));
    chk("key mirrored", 16'h0000, 16'(eep_u.num_key));
    chk("nv word", 16'hABCD, eep_u.mem[16]);
    cmd_result <= {8'h00, 8'h5A};
    bus(1'b1, 1'b0, 6'h07, 16'h3C12, rd);
    #1;
    chk("cmd strobe", 16'h0001, {14'h0000, cmd_strobe});
    chk("cmd word", 16'h3C12, cmd_word[0]);
    @(posedge sys_clk);
    #1;
    chk("cmd strobe end", 16'h0000, {14'h0000, cmd_strobe});
    bus(1'b0, 1'b0, 6'h07, 16'h0000, rd);
    chk("cmd read", 16'h5A12, rd);
    chk("upper data", 16'h0000, hrdata[31:16]);
    chk("bus response", 16'h0000, {15'h0000, hresp});
    diag_in <= {16'hBEEF, 16'h0000};
    pv_in <= {16'h0000, 16'h1234};
    bus(1'b1, 1'b1, 6'h1F, 16'h1235, rd);
    bus(1'b1, 1'b1, 6'h20, 16'h0101, rd);
    bus(1'b0, 1'b0, 6'h1F, 16'h0000, rd);
    chk("other key", 16'h0000, rd);
    chk("features 1", 16'h0101, features[1]);
    chk("features 0", 16'h0006, features[0]);
    chk("nv word ch1", 16'h0101, eep_u.mem[96]);
    bus(1'b0, 1'b1, 6'h06, 16'h0000, rd);
    chk("diagnostic", 16'hBEEF, rd);
    bus(1'b0, 1'b0, 6'h05, 16'h0000, rd);
    chk("live value", 16'h1234, rd);
    eep_u.restore(7'h11, 16'h7777);
    bus(1'b0, 1'b0, 6'h11, 16'h0000, rd);
    chk("restored", 16'h7777, rd);
    wr_rd(6'h3E, 16'h9696, rd);
    chk("write then read", 16'h9696, rd);
    wr_rd(6'h1F, 16'h1235, rd);
    chk("key at once", 16'h1235, rd);
    // A second reset must drop the unlock state of channel 1.
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(1'b0, 1'b1, 6'h1F, 16'h0000, rd);
    chk("key after reset", 16'h0000, rd);
    bus(1'b1, 1'b1, 6'h20, 16'h0F0F, rd);
    bus(1'b0, 1'b1, 6'h20, 16'h0000, rd);
    chk("features reset", 16'h0006, rd);
    test_done();
  end
endmodule

// File: test/trb_eeprom_model.sv
/*
  Serial EEPROM engine model standing behind the terminal register bank.
  Assumes the bank's registered parameter write port and its load port.
*/
`timescale 1ns/100ps
module trb_eeprom_model (
  input wire logic sys_clk,
  input wire logic nv_wr_valid,
  input wire trb_pkg::trb_nv_wr_t nv_wr,
  output logic nv_load,
  output trb_pkg::trb_nv_wr_t nv_load_word
);
  logic [15:0] mem [128];
  int num_wr = 0;
  int num_key = 0;

  initial
  begin
    nv_load = 1'b0;
    nv_load_word = '0;
  end

  // Every mirrored word is kept so that it can be replayed later.
  always @(posedge sys_clk)
  begin
    if (nv_wr_valid === 1'b1)
    begin
      mem[nv_wr.addr[6:0]] <= nv_wr.data;
      num_wr <= num_wr + 1;
      if (nv_wr.addr[5:0] === trb_pkg::IDX_WRITE_UNLOCK_KEY)
        num_key <= num_key + 1;
    end
  end

  // The word lines are inverted once released, so stale data never helps.
  task automatic restore(input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    nv_load <= 1'b1;
    nv_load_word <= {9'h000, a, d};
    @(posedge sys_clk);
    nv_load <= 1'b0;
    nv_load_word <= ~{9'h000, a, d};
  endtask
endmodule
